//--- ovf_fault_cal.sv
/*
 * Output overvoltage fault handling and current calibration settings.
 * Holds sense gain, sense offset, fault threshold and fault action,
 * compares output voltage, raises flags and alert, and runs latch-off
 * or timed retry. Assumes telemetry and the warning threshold arrive
 * on the same clock; straps and nothing else come from pins.
 */
`timescale 1ns/1ps
module ovf_fault_cal
    import ovf_pkg::*;
#(
    parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
)
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] CMD_CODE,
    input wire logic CMD_WR,
    input wire logic [15:0] CMD_WDATA,
    input wire logic CMD_RD,
    output logic [15:0] CMD_RDATA,
    output logic CMD_RVALID,
    output logic CMD_NACK,
    input wire logic [15:0] VOUT_MEAS,
    input wire logic [15:0] OV_WARN_LIMIT,
    input wire logic signed [15:0] IOUT_RAW,
    output logic signed [15:0] IOUT_CORR,
    output logic signed [23:0] SENSE_GAIN_Q4,
    input wire logic OUTPUT_ON_REQ,
    input wire logic BIAS_OK,
    input wire logic OTHER_FAULT_OFF,
    input wire logic [2:0] VOLTAGE_SET_STRAP,
    input wire logic [2:0] FIRST_CONFIG_STRAP,
    output logic OUTPUT_DISABLE,
    output logic RESTART_PULSE,
    output logic STATUS_VOUT_SUMMARY,
    output logic STATUS_OV_FAULT,
    output logic ALERT_OUTPUT_PIN_O,
    output logic ALERT_OUTPUT_PIN_OE
);
    localparam int UNIT_W = $clog2(RETRY_UNIT_CYCLES + 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] vset_s1_q, vset_s2_q;  // Voltage strap synchroniser
    logic [2:0] cfg_s1_q, cfg_s2_q;  // Config strap synchroniser
    logic init_q;  // Strap load pending after reset
    logic [15:0] gain_q;  // Sense gain word
    logic [15:0] offset_q;  // Sense offset word
    logic [15:0] ov_limit_q;  // Fault threshold
    logic [7:0] ov_action_q;  // Fault action byte
    logic [15:0] strap_ov;  // Threshold from strap
    logic [31:0] strap_prod;  // Strap voltage times scale
    logic signed [23:0] offset_q4;  // Decoded offset
    logic signed [23:0] offset_lim;  // Clamped offset
    logic signed [23:0] gain_q4;  // Decoded gain
    logic wr_clear;  // Clear-faults command
    logic ov_now;  // Voltage above threshold
    logic stop_retry;  // Outside stop of retrying
    logic retry_on;  // Fault action disables
    logic unit_end;  // Last cycle of a 35 ms unit
    logic delay_done;  // Whole retry delay spent
    logic flag_d;  // Next fault flag
    ovf_state_t state_q, state_d;  // Retry sequencer
    logic [UNIT_W-1:0] cyc_q;  // Cycles in current unit
    logic [2:0] units_q;  // Units spent

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    // Straps are pins: two flops before use
    always_ff @(posedge CLK) begin
        vset_s1_q <= VOLTAGE_SET_STRAP;
        vset_s2_q <= vset_s1_q;
        cfg_s1_q <= FIRST_CONFIG_STRAP;
        cfg_s2_q <= cfg_s1_q;
    end

    // Strap load one cycle after reset release
    always_ff @(posedge CLK) begin
        if (SRST) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    always_comb begin
        strap_prod = 32'(ovf_vset_volts(vset_s2_q)) * 32'(OV_SCALE_NUM) / 32'(OV_SCALE_DEN);
        strap_ov = strap_prod[15:0];
    end

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    assign wr_clear = CMD_WR && (CMD_CODE == CMD_CLEAR_FAULTS);

    // Calibration words, writes from host
    always_ff @(posedge CLK) begin
        if (SRST) begin
            gain_q <= SENSE_GAIN_RST;
            offset_q <= SENSE_OFFSET_RST;
        end else if (CMD_WR) begin
            if (CMD_CODE == CMD_SENSE_GAIN) begin
                gain_q <= CMD_WDATA;
            end
            if (CMD_CODE == CMD_SENSE_OFFSET) begin
                offset_q <= CMD_WDATA;
            end
        end
    end

    // Threshold and action, strap loaded after reset
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ov_limit_q <= 16'h0000;
            ov_action_q <= 8'h00;
        end else if (init_q) begin
            ov_limit_q <= (strap_ov > OV_LIMIT_MAX) ? OV_LIMIT_MAX : strap_ov;
            ov_action_q <= ovf_cfg_action(cfg_s2_q);
        end else if (CMD_WR) begin
            if (CMD_CODE == CMD_OV_LIMIT) begin
                ov_limit_q <= (CMD_WDATA > OV_LIMIT_MAX) ? OV_LIMIT_MAX : CMD_WDATA;
            end
            if (CMD_CODE == CMD_OV_ACTION) begin
                ov_action_q <= CMD_WDATA[7:0];
            end
        end
    end

    // Read answers and refusal of unknown codes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CMD_RDATA <= 16'h0000;
            CMD_RVALID <= 1'b0;
            CMD_NACK <= 1'b0;
        end else begin
            CMD_RVALID <= 1'b0;
            CMD_NACK <= 1'b0;
            if (CMD_RD) begin
                CMD_RVALID <= 1'b1;
                unique case (CMD_CODE)
                    CMD_SENSE_GAIN: CMD_RDATA <= gain_q;
                    CMD_SENSE_OFFSET: CMD_RDATA <= offset_q;
                    CMD_OV_LIMIT: CMD_RDATA <= ov_limit_q;
                    CMD_OV_ACTION: CMD_RDATA <= {8'h00, ov_action_q};
                    default: begin
                        CMD_RDATA <= 16'h0000;
                        CMD_RVALID <= 1'b0;
                        CMD_NACK <= 1'b1;
                    end
                endcase
            end else if (CMD_WR) begin
                // Unknown write codes are refused
                unique case (CMD_CODE)
                    CMD_SENSE_GAIN, CMD_SENSE_OFFSET, CMD_OV_LIMIT, CMD_OV_ACTION, CMD_CLEAR_FAULTS: ;
                    default: CMD_NACK <= 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Current calibration
    // ------------------------------------------------------------
    ovf_lin11_decode u_gain_dec (
        .word(gain_q),
        .value_q4(gain_q4)
    );

    ovf_lin11_decode u_offset_dec (
        .word(offset_q),
        .value_q4(offset_q4)
    );

    always_comb begin
        if (offset_q4 > OFFSET_MAX_Q4) begin
            offset_lim = OFFSET_MAX_Q4;
        end else if (offset_q4 < -OFFSET_MAX_Q4) begin
            offset_lim = -OFFSET_MAX_Q4;
        end else begin
            offset_lim = offset_q4;
        end
    end

    // Corrected current and decoded gain
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IOUT_CORR <= 16'sh0000;
            SENSE_GAIN_Q4 <= 24'sh000000;
        end else begin
            IOUT_CORR <= IOUT_RAW + offset_lim[15:0];
            SENSE_GAIN_Q4 <= gain_q4;
        end
    end

    // ------------------------------------------------------------
    // Fault compare, flags and alert
    // ------------------------------------------------------------
    assign ov_now = !init_q && (VOUT_MEAS > ov_limit_q);
    assign retry_on = (ov_action_q[MODE_HI:MODE_LO] == MODE_DISABLE_RETRY);
    assign stop_retry = !OUTPUT_ON_REQ || !BIAS_OK || OTHER_FAULT_OFF;

    always_comb begin
        flag_d = STATUS_OV_FAULT;
        if (wr_clear) begin
            flag_d = 1'b0;
        end
        if (ov_now) begin
            flag_d = 1'b1;
        end
    end

    // Status bits and open-drain alert
    always_ff @(posedge CLK) begin
        if (SRST) begin
            STATUS_OV_FAULT <= 1'b0;
            STATUS_VOUT_SUMMARY <= 1'b0;
            ALERT_OUTPUT_PIN_O <= 1'b0;
            ALERT_OUTPUT_PIN_OE <= 1'b0;
        end else begin
            STATUS_OV_FAULT <= flag_d;
            STATUS_VOUT_SUMMARY <= flag_d;
            ALERT_OUTPUT_PIN_O <= 1'b0;
            ALERT_OUTPUT_PIN_OE <= flag_d;
        end
    end

    // ------------------------------------------------------------
    // Retry sequencer
    // ------------------------------------------------------------
    assign unit_end = (cyc_q == UNIT_W'(RETRY_UNIT_CYCLES - 1));
    assign delay_done = unit_end && (units_q == ov_action_q[DELAY_HI:DELAY_LO]);

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (ov_now && retry_on) begin
                    if (ov_action_q[RETRY_HI:RETRY_LO] == RETRY_NONE) begin
                        state_d = ST_LATCHED;
                    end else begin
                        state_d = ST_DELAY;
                    end
                end
            end
            ST_LATCHED: state_d = ST_LATCHED;
            ST_DELAY: begin
                if (stop_retry) begin
                    state_d = ST_RUN;
                end else if (delay_done) begin
                    state_d = ST_WAIT_LOW;
                end
            end
            ST_WAIT_LOW: begin
                if (stop_retry || (VOUT_MEAS < OV_WARN_LIMIT)) begin
                    state_d = ST_RUN;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || state_q != ST_DELAY) begin
            cyc_q <= '0;
            units_q <= 3'h0;
        end else if (unit_end) begin
            cyc_q <= '0;
            units_q <= units_q + 3'h1;
        end else begin
            cyc_q <= cyc_q + UNIT_W'(1);
        end
    end

    // Disable and restart outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            OUTPUT_DISABLE <= 1'b0;
            RESTART_PULSE <= 1'b0;
        end else begin
            OUTPUT_DISABLE <= (state_d != ST_RUN);
            RESTART_PULSE <= (state_q == ST_WAIT_LOW) && !stop_retry && (VOUT_MEAS < OV_WARN_LIMIT);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [31:0] dly_cnt_q;  // Cycles spent in delay
    always_ff @(posedge CLK) begin
        if (SRST || state_q != ST_DELAY) begin
            dly_cnt_q <= 32'h0;
        end else begin
            dly_cnt_q <= dly_cnt_q + 32'h1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    property p_cal_reset;
        $fell(SRST) |-> (gain_q == SENSE_GAIN_RST) && (offset_q == SENSE_OFFSET_RST);
    endproperty
    a_cal_reset: assert property (p_cal_reset) else $error("calibration reset value wrong");
    property p_offset_clamp;
        (offset_lim <= OFFSET_MAX_Q4) && (offset_lim >= -OFFSET_MAX_Q4);
    endproperty
    a_offset_clamp: assert property (p_offset_clamp) else $error("offset outside ten amps");
    property p_limit_span;
        ov_limit_q <= OV_LIMIT_MAX;
    endproperty
    a_limit_span: assert property (p_limit_span) else $error("threshold above six volts");
    property p_strap_load;
        init_q |=> (ov_limit_q == $past(strap_ov)) && (ov_action_q == ovf_cfg_action($past(cfg_s2_q)));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("strap defaults not loaded");
    property p_flag_alert;
        ov_now |=> STATUS_OV_FAULT && STATUS_VOUT_SUMMARY && ALERT_OUTPUT_PIN_OE && !ALERT_OUTPUT_PIN_O;
    endproperty
    a_flag_alert: assert property (p_flag_alert) else $error("fault not flagged or alert not low");
    property p_flag_sticky;
        STATUS_OV_FAULT && !wr_clear |=> STATUS_OV_FAULT;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("fault flag dropped without clear");
    property p_latched;
        state_q == ST_LATCHED |=> (state_q == ST_LATCHED) && OUTPUT_DISABLE;
    endproperty
    a_latched: assert property (p_latched) else $error("latched output re-enabled");
    property p_restart_low;
        RESTART_PULSE |-> $past(VOUT_MEAS < OV_WARN_LIMIT) && !OUTPUT_DISABLE;
    endproperty
    a_restart_low: assert property (p_restart_low) else $error("restart above warning level");
    property p_delay_len;
        (state_q == ST_DELAY) && (state_d == ST_WAIT_LOW)
            |-> dly_cnt_q + 32'h1 == (32'(ov_action_q[DELAY_HI:DELAY_LO]) + 32'h1) * 32'(RETRY_UNIT_CYCLES);
    endproperty
    a_delay_len: assert property (p_delay_len) else $error("retry delay length wrong");
    property p_unused_mode;
        (state_q == ST_RUN) && ov_now && !retry_on |=> (state_q == ST_RUN) && !OUTPUT_DISABLE;
    endproperty
    a_unused_mode: assert property (p_unused_mode) else $error("unused action disabled output");
endmodule : ovf_fault_cal

//--- ovf_pkg.sv
/*
 * Shared constants for the output overvoltage fault and current
 * calibration block: command codes, field positions, reset values,
 * strap decode tables, retry timing and the retry state type.
 * Assumes a 20 MHz core clock and values in the
 * exponent/mantissa and unsigned 2^-13 volt formats.
 */
package ovf_pkg;
    // ------------------------------------------------------------
    // Command codes of the management bus
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_SENSE_GAIN = 8'h38;
    localparam logic [7:0] CMD_SENSE_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_OV_ACTION = 8'h41;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] SENSE_GAIN_RST = 16'hca66;
    localparam logic [15:0] SENSE_OFFSET_RST = 16'h0000;
    localparam logic [15:0] OV_LIMIT_MAX = 16'hc000;
    localparam logic signed [23:0] OFFSET_MAX_Q4 = 24'sh0000a0;
    localparam int OV_SCALE_NUM = 11;
    localparam int OV_SCALE_DEN = 10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MANT_HI = 10;
    localparam int IOUT_FRAC_BITS = 4;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    // ------------------------------------------------------------
    // Retry timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    // Retry sequencer states
    typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_DELAY, ST_WAIT_LOW} ovf_state_t;

    // Output voltage chosen by the voltage-set strap, 2^-13 V units
    function automatic logic [15:0] ovf_vset_volts(input logic [2:0] code);
        case (code)
            3'h0: ovf_vset_volts = 16'h1333;
            3'h1: ovf_vset_volts = 16'h199a;
            3'h2: ovf_vset_volts = 16'h2000;
            3'h3: ovf_vset_volts = 16'h2666;
            3'h4: ovf_vset_volts = 16'h3000;
            3'h5: ovf_vset_volts = 16'h399a;
            3'h6: ovf_vset_volts = 16'h5000;
            default: ovf_vset_volts = 16'h6999;
        endcase
    endfunction : ovf_vset_volts

    // Fault action chosen by the first configuration strap
    function automatic logic [7:0] ovf_cfg_action(input logic [2:0] code);
        case (code)
            3'h0: ovf_cfg_action = 8'h80;
            3'h1: ovf_cfg_action = 8'hb8;
            3'h2: ovf_cfg_action = 8'hbb;
            3'h3: ovf_cfg_action = 8'hbf;
            3'h4: ovf_cfg_action = 8'h88;
            3'h5: ovf_cfg_action = 8'h8f;
            3'h6: ovf_cfg_action = 8'h00;
            default: ovf_cfg_action = 8'h80;
        endcase
    endfunction : ovf_cfg_action
endpackage : ovf_pkg

//--- ovf_lin11_decode.sv
/*
 * Decoder from the exponent/mantissa format to a signed fixed-point
 * value with four fraction bits.
 * Assumes a pure combinational use inside the main block.
 */
`timescale 1ns/1ps
module ovf_lin11_decode
    import ovf_pkg::*;
(
    input wire logic [15:0] word,
    output logic signed [23:0] value_q4
);
    logic signed [4:0] expo;  // Signed exponent
    logic signed [10:0] mant;  // Signed mantissa
    logic signed [5:0] shift;  // Exponent plus fraction bits
    logic signed [39:0] wide;  // Sign-extended mantissa

    // ------------------------------------------------------------
    // Shift mantissa by exponent
    // ------------------------------------------------------------
    always_comb begin
        expo = $signed(word[EXP_HI:EXP_LO]);
        mant = $signed(word[MANT_HI:0]);
        shift = $signed({expo[4], expo}) + 6'(IOUT_FRAC_BITS);
        wide = {{29{mant[10]}}, mant};
        // Left for positive, arithmetic right for negative
        if (shift >= 6'sd0) begin
            wide = wide <<< shift[4:0];
        end else begin
            wide = wide >>> 6'(-shift);
        end
        value_q4 = wide[23:0];
    end
endmodule : ovf_lin11_decode

//--- ovf_host_model.sv
/*
 * Host model for the fault and calibration block: drives the command
 * bus one request at a time and supplies the warning threshold.
 * Assumes the command bus contract of the block and a shared clock.
 */
`timescale 1ns/1ps
module ovf_host_model
    import ovf_pkg::*;
(
    input wire logic clk,
    output logic [7:0] cmd_code,
    output logic cmd_wr,
    output logic [15:0] cmd_wdata,
    output logic cmd_rd,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_rvalid,
    input wire logic cmd_nack,
    output logic [15:0] ov_warn_limit
)
;
    // ------------------------------------------------
    // Idle bus and warning level
    // ------------------------------------------------
    initial begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_wdata = 16'h0000;
        cmd_rd = 1'b0;
        ov_warn_limit = 16'h1800;
    end

    // One request, held for one edge, answer taken next cycle
    task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic v, output logic nk);
        @(posedge clk);
        cmd_code <= c;
        cmd_wdata <= d;
        cmd_rd <= rd;
        cmd_wr <= !rd;
        @(posedge clk);
        cmd_rd <= 1'b0;
        cmd_wr <= 1'b0;
        // Released data shows a changed pattern
        cmd_wdata <= ~d;
        #1;
        q = cmd_rdata;
        v = cmd_rvalid;
        nk = cmd_nack;
    endtask : xfer
endmodule : ovf_host_model

//--- tb_top.sv
/*
 * Self-checking bench for the fault and calibration block.
 * Assumes a shortened retry unit and fixed strap codes.
 */
`timescale 1ns/1ps
module tb_top
    import ovf_pkg::*;
;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    localparam int U = 8;
    localparam logic [15:0] OV_RST = 16'((32'h2000 * 11) / 10);
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] vout = 16'h0000;
    logic signed [15:0] iraw = 16'h0000;
    logic bias_ok = 1'b1;
    logic on_req = 1'b1;
    logic oth_off = 1'b0;
    logic [7:0] code;
    logic wr_s, rd_s, rvalid, nack, dis, rst_p, summ, ovf, alo, aloe;
    logic [15:0] wdata, rdata, warn, q;
    logic signed [15:0] icorr;
    logic signed [23:0] gq4;
    logic v, nk;
    int cnt;
    int mismatches = 0;
    int checks_done = 0;
    logic [2:0] dl [2] = '{3'h0, 3'h7};

    initial begin
        forever #25 clk = ~clk;
    end

    ovf_fault_cal #(.RETRY_UNIT_CYCLES(U)) i_ovf_fault_cal (.CLK(clk), .SRST(srst), .CMD_CODE(code),
        .CMD_WR(wr_s), .CMD_WDATA(wdata), .CMD_RD(rd_s), .CMD_RDATA(rdata), .CMD_RVALID(rvalid),
        .CMD_NACK(nack), .VOUT_MEAS(vout), .OV_WARN_LIMIT(warn), .IOUT_RAW(iraw), .IOUT_CORR(icorr),
        .SENSE_GAIN_Q4(gq4), .OUTPUT_ON_REQ(on_req), .BIAS_OK(bias_ok), .OTHER_FAULT_OFF(oth_off),
        .VOLTAGE_SET_STRAP(3'h2), .FIRST_CONFIG_STRAP(3'h0), .OUTPUT_DISABLE(dis),
        .RESTART_PULSE(rst_p), .STATUS_VOUT_SUMMARY(summ), .STATUS_OV_FAULT(ovf),
        .ALERT_OUTPUT_PIN_O(alo), .ALERT_OUTPUT_PIN_OE(aloe));

    ovf_host_model i_ovf_host_model (.clk(clk), .cmd_code(code), .cmd_wr(wr_s), .cmd_wdata(wdata),
        .cmd_rd(rd_s), .cmd_rdata(rdata), .cmd_rvalid(rvalid), .cmd_nack(nack), .ov_warn_limit(warn));

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        vout <= 16'h0000;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_ovf_host_model.xfer(1'b0, c, d, q, v, nk);
    endtask : wr

    task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
        i_ovf_host_model.xfer(1'b1, c, 16'h0000, q, v, nk);
        chk("read valid", v, 1'b1);
        chk("read data", q, exp);
    endtask : rdchk

    // Applies a level and waits the one-cycle fault answer
    task automatic apply_ov(input logic [15:0] lvl);
        @(posedge clk);
        vout <= lvl;
        @(posedge clk);
        #1;
    endtask : apply_ov

    // Sets the raw current and checks the corrected value
    task automatic iout(input logic [15:0] raw, input logic [15:0] exp);
        @(posedge clk);
        iraw <= raw;
        @(posedge clk);
        #1 chk("corrected current", $unsigned(icorr), exp);
    endtask : iout

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1 seen |= (rst_p !== 1'b0);
        end
        chk("no restart", seen, 1'b0);
    endtask : quiet

    // Bounded wait for a restart attempt
    task automatic wait_pulse(input int lim);
        cnt = 0;
        while (rst_p !== 1'b1) begin
            @(posedge clk);
            #1 cnt++;
            if (cnt > lim) begin
                mismatches++;
                give_verdict();
            end
        end
    endtask : wait_pulse

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        do_reset();
        rdchk(CMD_SENSE_GAIN, 16'hca66);
        rdchk(CMD_SENSE_OFFSET, 16'h0000);
        rdchk(CMD_OV_LIMIT, OV_RST);
        rdchk(CMD_OV_ACTION, 16'h0080);
        i_ovf_host_model.xfer(1'b1, 8'h55, 16'h0000, q, v, nk);
        chk("unknown nack", {nk, v, q}, 18'h20000);
        $display("test resets done");
        // Offset and gain decode
        wr(CMD_SENSE_OFFSET, 16'h0002);
        iout(16'h0010, 16'h0030);
        wr(CMD_SENSE_OFFSET, 16'hf804);
        iout(16'h0010, 16'h0030);
        wr(CMD_SENSE_OFFSET, 16'h07fe);
        iout(16'h0010, 16'hfff0);
        wr(CMD_SENSE_OFFSET, 16'h0014);
        iout(16'h0010, 16'h00b0);
        wr(CMD_SENSE_GAIN, 16'h0803);
        repeat (2) @(posedge clk);
        chk("gain decode", gq4, 24'h000060);
        wr(CMD_SENSE_GAIN, 16'hf810);
        repeat (2) @(posedge clk);
        chk("gain decode", gq4, 24'h000080);
        rdchk(CMD_SENSE_GAIN, 16'hf810);
        wr(CMD_OV_LIMIT, 16'hffff);
        rdchk(CMD_OV_LIMIT, 16'hc000);
        $display("test calibration done");
        // Flags only, then latch-off
        wr(CMD_OV_LIMIT, 16'h2000);
        wr(CMD_OV_ACTION, 16'h0000);
        apply_ov(16'h2000);
        chk("no fault at limit", ovf, 1'b0);
        apply_ov(16'h2001);
        chk("fault flags", {summ, ovf, aloe, alo}, 4'he);
        chk("flags only", dis, 1'b0);
        apply_ov(16'h0000);
        chk("flag sticky", ovf, 1'b1);
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        @(posedge clk);
        #1 chk("flags cleared", {summ, ovf, aloe}, 3'h0);
        wr(CMD_OV_ACTION, 16'h0080);
        apply_ov(16'h2001);
        chk("disabled", dis, 1'b1);
        apply_ov(16'h0000);
        quiet(5 * U);
        chk("latched off", {dis, ovf}, 2'h3);
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        @(posedge clk);
        #1 chk("latched after clear", {dis, ovf}, 2'h2);
        $display("test latch done");
        // Timed retry at both delay extremes
        do_reset();
        wr(CMD_OV_LIMIT, 16'h2000);
        for (int i = 0; i < 2; i++) begin
            wr(CMD_OV_ACTION, {8'h00, 8'h88 | {5'h00, dl[i]}});
            apply_ov(16'h2001);
            chk("retry disable", dis, 1'b1);
            @(posedge clk);
            vout <= 16'h0000;
            wait_pulse(100);
            chk("retry spacing", 24'(cnt), 24'((dl[i] + 1) * U));
            chk("restart enables", dis, 1'b0);
        end
        // Restart held off at the warning level
        wr(CMD_OV_ACTION, 16'h0088);
        apply_ov(16'h2001);
        @(posedge clk);
        vout <= 16'h1800;
        quiet(3 * U);
        @(posedge clk);
        vout <= 16'h17ff;
        wait_pulse(4);
        chk("restart after drop", 24'(cnt), 24'h000001);
        // Bias loss, turn-off and another fault each stop the retry
        for (int k = 0; k < 3; k++) begin
            apply_ov(16'h2001);
            @(posedge clk);
            vout <= 16'h0000;
            bias_ok <= (k != 0);
            on_req <= (k != 1);
            oth_off <= (k == 2);
            repeat (2) @(posedge clk);
            #1 chk("stopped", dis, 1'b0);
            quiet(3 * U);
            @(posedge clk);
            bias_ok <= 1'b1;
            on_req <= 1'b1;
            oth_off <= 1'b0;
        end
        $display("test retry done");
        give_verdict();
    end
endmodule : tb_top
